// [design/pm_cmd_bank.v]
// power module management command bank behind an SMBus slave
`timescale 1ns/100ps
`default_nettype none
`include "pm_bank_consts.vh"
module pm_cmd_bank #(
   parameter [5:0] MODULE_NAME = 6'h2A, // arbitrary neutral designation
   parameter [7:0] FW_REV      = 8'h10,
   parameter       DROOP_SHARE = 0
) (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        scl_pin,
   input  wire        sda_in,
   output wire        sda_out,
   output reg         sda_oe_n,
   input  wire [6:0]  addr_strap,
   input  wire        alert_line,
   input  wire [15:0] vin_meas,
   input  wire [15:0] vout_meas,
   input  wire [15:0] iout_meas,
   input  wire [15:0] temp_meas,
   output reg  [7:0]  comm_error_status,
   output reg         write_protect_enable,
   output reg  [15:0] vo_read_gain_trim,
   output reg  [15:0] vo_read_offset_trim,
   output reg  [15:0] vi_read_gain_trim,
   output reg  [15:0] vi_read_offset_trim,
   output reg  [15:0] io_gain_trim,
   output reg  [15:0] io_offset_trim,
   output wire [10:0] vi_offset_mantissa,
   output reg  [4:0]  pin_function_alert_cfg,
   output wire        ara_mode,
   output wire        c1_secondary_onoff,
   output wire        c1_trim,
   output wire        c2_power_good,
   output wire        c2_secondary_onoff
);
   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_RX   = 3'd1;
   localparam [2:0] S_ACK  = 3'd2;
   localparam [2:0] S_TX   = 3'd3;
   localparam [2:0] S_MACK = 3'd4;
   localparam [2:0] S_SKIP = 3'd5;

   wire       scl_s;
   wire       sda_s;
   wire [6:0] own_addr;
   reg        scl_d;
   reg        sda_d;
   reg  [2:0] st;
   reg  [3:0] bcnt;
   reg  [7:0] sreg;
   reg  [7:0] txsh;
   reg  [7:0] crc;
   reg  [7:0] cmd;
   reg  [7:0] wlo;
   reg  [7:0] whi;
   reg  [2:0] nrx;
   reg  [1:0] ntx;
   reg        is_addr;
   reg        rd;
   reg        ara_txn;
   reg        wr_txn;
   bit_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_scl (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (scl_pin),
      .q       (scl_s)
   );
   bit_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sda (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (sda_in),
      .q       (sda_s)
   );
   bit_sync #(.WIDTH(7), .RST_VAL(1'b0)) u_addr (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (addr_strap),
      .q       (own_addr)
   );
   function [7:0] crc8;
      input [7:0] c;
      input [7:0] d;
      integer     i;
      reg   [7:0] x;
      begin
         x = c ^ d;
         for (i = 0; i < 8; i = i + 1) begin
            x = x[7] ? ({x[6:0], 1'b0} ^ `CRC_POLY) : {x[6:0], 1'b0};
         end
         crc8 = x;
      end
   endfunction
   wire start_det = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire byte_done = (st == S_RX) & scl_fall & (bcnt == 4'd8);
   // alert response takes over the address only while the alert is up
   assign ara_mode = pin_function_alert_cfg[`CFG_ARA_BIT] & alert_line;
   wire addr_hit = ara_mode ? (sreg[7:1] == `ARA_ADDR)
                            : (sreg[7:1] == own_addr);
   assign sda_out = 1'b0;
   assign vi_offset_mantissa = vi_read_offset_trim[10:0];
   wire [3:0] pin_map = pin_function_alert_cfg[3:0];
   assign c1_secondary_onoff = (pin_map == `PIN_MAP_ONOFF_PG);
   assign c2_power_good      = (pin_map == `PIN_MAP_ONOFF_PG);
   assign c1_trim            = (pin_map == `PIN_MAP_TRIM_ONOFF);
   assign c2_secondary_onoff = (pin_map == `PIN_MAP_TRIM_ONOFF);
   // command decode and read data
   reg        known;
   reg        known_next;
   reg        is_byte;
   reg [15:0] rd_word;
   always @* begin
      known   = 1'b1;
      is_byte = 1'b0;
      rd_word = 16'h0000;
      case (cmd)
         `CMD_COMM_STATUS: begin
            is_byte = 1'b1;
            rd_word = {8'h00, comm_error_status};
         end
         `CMD_VIN_READ:  rd_word = vin_meas;
         `CMD_VOUT_READ: rd_word = vout_meas;
         `CMD_IOUT_READ: rd_word = iout_meas;
         `CMD_TEMP_READ: rd_word = temp_meas;
         `CMD_KIND_PROTECT:
            rd_word = {8'h00, MODULE_NAME, write_protect_enable, 1'b0};
         `CMD_VO_GAIN:   rd_word = vo_read_gain_trim;
         `CMD_VO_OFFSET: rd_word = vo_read_offset_trim;
         `CMD_VI_GAIN:   rd_word = vi_read_gain_trim;
         `CMD_VI_OFFSET: rd_word = vi_read_offset_trim;
         `CMD_IO_GAIN:   rd_word = io_gain_trim;
         `CMD_IO_OFFSET: rd_word = io_offset_trim;
         `CMD_FW_REV: begin
            is_byte = 1'b1;
            rd_word = {8'h00, FW_REV};
         end
         `CMD_PIN_CFG: begin
            is_byte = 1'b1;
            rd_word = {8'h00, 3'b000, pin_function_alert_cfg};
         end
         default: known = 1'b0;
      endcase
   end
   // byte to put on the wire next; checksum follows the data
   wire [1:0] len_tx  = is_byte ? 2'd1 : 2'd2;
   wire       tx_data = ara_txn ? (ntx == 2'd0) : (ntx < len_tx);
   reg  [7:0] tx_byte;
   always @* begin
      if (ara_txn)
         tx_byte = (ntx == 2'd0) ? {own_addr, 1'b0} :
                   ((ntx == 2'd1) ? crc : 8'hFF);
      else if (!known)
         tx_byte = 8'hFF;
      else if (ntx == 2'd0)
         tx_byte = rd_word[7:0];
      else if (ntx == 2'd1 && !is_byte)
         tx_byte = rd_word[15:8];
      else if (ntx == len_tx)
         tx_byte = crc;
      else
         tx_byte = 8'hFF;
   end
   wire load_tx = scl_fall & (((st == S_ACK) & rd) | (st == S_MACK));
   // write commit at stop; payload is data plus optional checksum
   wire [15:0] wword   = {whi, wlo};
   wire [4:0]  wexp    = wword[`EXP_MSB:`EXP_LSB];
   wire [2:0]  npay    = nrx - 3'd1;
   wire [2:0]  len_rx  = is_byte ? 3'd1 : 3'd2;
   wire        commit  = stop_det & wr_txn & (nrx >= 3'd2);
   wire        pec_bad = (npay == len_rx + 3'd1) & (crc != 8'h00);
   wire        len_bad = (npay != len_rx) & (npay != len_rx + 3'd1);
   wire        good    = commit & known & ~pec_bad & ~len_bad;
   wire gain_ok = (wword >= `GAIN_MIN) && (wword <= `GAIN_MAX);
   wire map_ok  = (wlo[3:0] == `PIN_MAP_ONOFF_PG) ||
                  ((DROOP_SHARE == 0) && (wlo[3:0] == `PIN_MAP_TRIM_ONOFF));
   reg       accept;
   reg [7:0] set_mask;
   reg [7:0] clr_mask;
   always @* begin
      accept   = 1'b0;
      set_mask = 8'h00;
      clr_mask = 8'h00;
      if (byte_done && !is_addr && nrx == 3'd0 && !known_next)
         set_mask[`ST_BAD_CMD] = 1'b1;
      if (commit && known && pec_bad)
         set_mask[`ST_PEC_FAIL] = 1'b1;
      if (commit && known && !pec_bad && len_bad)
         set_mask[`ST_BAD_DATA] = 1'b1;
      if (good) begin
         case (cmd)
            `CMD_COMM_STATUS: clr_mask = wlo & `ST_IMPL_MASK;
            `CMD_KIND_PROTECT: accept = 1'b1;
            `CMD_PIN_CFG: accept = map_ok;
            `CMD_VO_GAIN, `CMD_VI_GAIN, `CMD_IO_GAIN:
               accept = ~write_protect_enable & gain_ok;
            `CMD_VO_OFFSET: accept = ~write_protect_enable & (wexp == `VO_OFF_EXP);
            `CMD_VI_OFFSET: accept = ~write_protect_enable & (wexp == `VI_OFF_EXP);
            `CMD_IO_OFFSET: accept = ~write_protect_enable & (wexp == `IO_OFF_EXP);
            default: accept = 1'b0;
         endcase
         if (!accept && cmd != `CMD_COMM_STATUS)
            set_mask[`ST_BAD_DATA] = 1'b1;
      end
   end
   // the command byte is classified as it arrives, before cmd updates
   always @* begin
      case (sreg)
         `CMD_COMM_STATUS, `CMD_VIN_READ, `CMD_VOUT_READ, `CMD_IOUT_READ,
         `CMD_TEMP_READ, `CMD_KIND_PROTECT, `CMD_VO_GAIN, `CMD_VO_OFFSET,
         `CMD_VI_GAIN, `CMD_VI_OFFSET, `CMD_IO_GAIN, `CMD_IO_OFFSET,
         `CMD_FW_REV, `CMD_PIN_CFG: known_next = 1'b1;
         default: known_next = 1'b0;
      endcase
   end
   always @(posedge clk_sys) begin
      if (rst) begin
         scl_d                  <= 1'b1;
         sda_d                  <= 1'b1;
         sda_oe_n               <= 1'b1;
         st                     <= S_IDLE;
         bcnt                   <= 4'd0;
         sreg                   <= 8'h00;
         txsh                   <= 8'hFF;
         crc                    <= 8'h00;
         cmd                    <= 8'h00;
         wlo                    <= 8'h00;
         whi                    <= 8'h00;
         nrx                    <= 3'd0;
         ntx                    <= 2'd0;
         is_addr                <= 1'b0;
         rd                     <= 1'b0;
         ara_txn                <= 1'b0;
         wr_txn                 <= 1'b0;
         comm_error_status      <= 8'h00;
         write_protect_enable   <= 1'b0;
         vo_read_gain_trim      <= `GAIN_RESET;
         vi_read_gain_trim      <= `GAIN_RESET;
         io_gain_trim           <= `GAIN_RESET;
         vo_read_offset_trim    <= `VO_OFF_RESET;
         vi_read_offset_trim    <= `VI_OFF_RESET;
         io_offset_trim         <= `IO_OFF_RESET;
         pin_function_alert_cfg <= 5'b00000;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         // set wins over a clear landing in the same cycle
         comm_error_status <= ((comm_error_status & ~clr_mask) | set_mask)
                              & `ST_IMPL_MASK;
         if (accept) begin
            case (cmd)
               `CMD_KIND_PROTECT: write_protect_enable <= wlo[`WPE_BIT];
               `CMD_PIN_CFG: pin_function_alert_cfg <= wlo[`CFG_WIDTH-1:0];
               `CMD_VO_GAIN:   vo_read_gain_trim   <= wword;
               `CMD_VI_GAIN:   vi_read_gain_trim   <= wword;
               `CMD_IO_GAIN:   io_gain_trim        <= wword;
               `CMD_VO_OFFSET: vo_read_offset_trim <= wword;
               `CMD_VI_OFFSET: vi_read_offset_trim <= wword;
               `CMD_IO_OFFSET: io_offset_trim      <= wword;
               default: ;
            endcase
         end
         sda_oe_n <= ~((st == S_ACK) | ((st == S_TX) & ~txsh[7]));
         if (load_tx) begin
            st   <= S_TX;
            txsh <= tx_byte;
            // saturate so bytes after the checksum stay all ones
            if (ntx != 2'd3)
               ntx <= ntx + 2'd1;
            if (tx_data)
               crc <= crc8(crc, tx_byte);
         end
         if (start_det) begin
            st      <= S_RX;
            bcnt    <= 4'd0;
            is_addr <= 1'b1;
            wr_txn  <= 1'b0;
            // a repeated start keeps the command and running checksum
            if (st == S_IDLE || st == S_SKIP) begin
               crc <= 8'h00;
               nrx <= 3'd0;
            end
         end else if (stop_det) begin
            st     <= S_IDLE;
            wr_txn <= 1'b0;
         end else begin
            case (st)
               S_RX: begin
                  if (scl_rise) begin
                     sreg <= {sreg[6:0], sda_s};
                     bcnt <= bcnt + 4'd1;
                  end else if (byte_done) begin
                     bcnt <= 4'd0;
                     crc  <= crc8(crc, sreg);
                     if (is_addr) begin
                        if (addr_hit) begin
                           st      <= S_ACK;
                           is_addr <= 1'b0;
                           rd      <= sreg[0];
                           ara_txn <= ara_mode;
                           wr_txn  <= ~sreg[0] & ~ara_mode;
                           ntx     <= 2'd0;
                        end else begin
                           st <= S_SKIP;
                        end
                     end else begin
                        st <= S_ACK;
                        if (nrx != 3'd7)
                           nrx <= nrx + 3'd1;
                        if (nrx == 3'd0)
                           cmd <= sreg;
                        if (nrx == 3'd1)
                           wlo <= sreg;
                        if (nrx == 3'd2)
                           whi <= sreg;
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall && !rd)
                     st <= S_RX;
               end
               S_TX: begin
                  if (scl_rise) begin
                     bcnt <= bcnt + 4'd1;
                  end else if (scl_fall) begin
                     if (bcnt == 4'd8) begin
                        st   <= S_MACK;
                        bcnt <= 4'd0;
                     end else begin
                        txsh <= {txsh[6:0], 1'b1};
                     end
                  end
               end
               S_MACK: begin
                  // a not-acknowledge ends the read; the bus is let go
                  if (scl_rise && sda_s)
                     st <= S_SKIP;
               end
               S_SKIP: ;
               S_IDLE: ;
               default: st <= S_IDLE;
            endcase
         end
      end
   end
endmodule // pm_cmd_bank
`default_nettype wire

// [inc/pm_bank_consts.vh]
// command codes, field layouts, reset values and limits of the management bank
`ifndef PM_BANK_CONSTS_VH
`define PM_BANK_CONSTS_VH
`define CMD_COMM_STATUS   8'h7E
`define CMD_VIN_READ      8'h88
`define CMD_VOUT_READ     8'h8B
`define CMD_IOUT_READ     8'h8C
`define CMD_TEMP_READ     8'h8D
`define CMD_KIND_PROTECT  8'hD0
`define CMD_VO_GAIN       8'hD1
`define CMD_VO_OFFSET     8'hD2
`define CMD_VI_GAIN       8'hD3
`define CMD_VI_OFFSET     8'hD4
`define CMD_IO_GAIN       8'hD6
`define CMD_IO_OFFSET     8'hD7
`define CMD_FW_REV        8'hDB
`define CMD_PIN_CFG       8'hE0
`define ST_BAD_CMD        7
`define ST_BAD_DATA       6
`define ST_PEC_FAIL       5
`define ST_IMPL_MASK      8'hE0
`define WPE_BIT           1
`define NAME_MSB          7
`define NAME_LSB          2
`define CFG_ARA_BIT       4
`define CFG_WIDTH         5
`define PIN_MAP_ONOFF_PG  4'h0
`define PIN_MAP_TRIM_ONOFF 4'h2
`define GAIN_RESET        16'h2000
`define GAIN_MIN          16'h1999
`define GAIN_MAX          16'h2666
`define EXP_MSB           15
`define EXP_LSB           11
`define VO_OFF_EXP        5'h14
`define VI_OFF_EXP        5'h1D
`define IO_OFF_EXP        5'h1C
`define VO_OFF_RESET      16'hA000
`define VI_OFF_RESET      16'hE800
`define IO_OFF_RESET      16'hE000
`define ARA_ADDR          7'h0C
`define CRC_POLY          8'h07
`endif

// [design/bit_sync.v]
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
   parameter       WIDTH   = 1,
   parameter [0:0] RST_VAL = 1'b1
) (
   input  wire             clk_sys,
   input  wire             rst,
   input  wire [WIDTH-1:0] d,
   output reg  [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta;

   always @(posedge clk_sys) begin
      if (rst) begin
         meta <= {WIDTH{RST_VAL}};
         q    <= {WIDTH{RST_VAL}};
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // bit_sync
`default_nettype wire

// [bench/pm_cmd_bank_properties.sv]
// port assertions for the management command bank
`timescale 1ns/100ps
`default_nettype none
module pm_cmd_bank_properties (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        scl_pin,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe_n,
   input wire logic [6:0]  addr_strap,
   input wire logic        alert_line,
   input wire logic [15:0] vin_meas,
   input wire logic [15:0] vout_meas,
   input wire logic [15:0] iout_meas,
   input wire logic [15:0] temp_meas,
   input wire logic [7:0]  comm_error_status,
   input wire logic        write_protect_enable,
   input wire logic [15:0] vo_read_gain_trim,
   input wire logic [15:0] vo_read_offset_trim,
   input wire logic [15:0] vi_read_gain_trim,
   input wire logic [15:0] vi_read_offset_trim,
   input wire logic [15:0] io_gain_trim,
   input wire logic [15:0] io_offset_trim,
   input wire logic [10:0] vi_offset_mantissa,
   input wire logic [4:0]  pin_function_alert_cfg,
   input wire logic        ara_mode,
   input wire logic        c1_secondary_onoff,
   input wire logic        c1_trim,
   input wire logic        c2_power_good,
   input wire logic        c2_secondary_onoff
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence wp_held;
      write_protect_enable ##1 write_protect_enable;
   endsequence
   status_unimpl_a: assert property ((comm_error_status & 8'h1F) == 8'h00)
      else $error("unsupported status bit set");
   // clears land only after a stop, with the clock line idle high
   status_sticky_a: assert property (|($past(comm_error_status) & ~comm_error_status)
      |-> $past(scl_pin, 2) && $past(scl_pin, 5)) else $error("status cleared mid-frame");
   wpe_at_stop_a: assert property ($changed(write_protect_enable)
      |-> $past(scl_pin, 2) && $past(scl_pin, 5)) else $error("protect changed mid-frame");
   gain_range_a: assert property (vo_read_gain_trim inside {[16'h1999:16'h2666]}
      && vi_read_gain_trim inside {[16'h1999:16'h2666]}
      && io_gain_trim inside {[16'h1999:16'h2666]}) else $error("gain out of range");
   offset_exp_a: assert property (vo_read_offset_trim[15:11] == 5'h14
      && vi_read_offset_trim[15:11] == 5'h1D
      && io_offset_trim[15:11] == 5'h1C) else $error("offset exponent wrong");
   vi_mantissa_a: assert property (vi_offset_mantissa == vi_read_offset_trim[10:0])
      else $error("mantissa mismatch");
   trims_locked_a: assert property (wp_held |-> $stable(vo_read_gain_trim)
      && $stable(vo_read_offset_trim) && $stable(vi_read_gain_trim)
      && $stable(vi_read_offset_trim) && $stable(io_gain_trim)
      && $stable(io_offset_trim)) else $error("trim changed while protected");
   ara_mode_a: assert property (ara_mode == (pin_function_alert_cfg[4] && alert_line))
      else $error("alert response mode wrong");
   onoff_good_map_a: assert property (c1_secondary_onoff == (pin_function_alert_cfg[3:0] == 4'h0)
      && c2_power_good == (pin_function_alert_cfg[3:0] == 4'h0)) else $error("map 0 wrong");
   trim_onoff_map_a: assert property (c1_trim == (pin_function_alert_cfg[3:0] == 4'h2)
      && c2_secondary_onoff == (pin_function_alert_cfg[3:0] == 4'h2)) else $error("map 2 wrong");
   pin_map_legal_a: assert property (pin_function_alert_cfg[3:0] inside {4'h0, 4'h2})
      else $error("undefined pin map held");
endmodule // pm_cmd_bank_properties
`default_nettype wire

// [bench/smbus_host_model.sv]
// bit-level management bus host driving the command bank
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
   input  wire logic [6:0] dev_addr,
   input  wire logic       sda_wire,
   output var  logic       scl,
   output var  logic       sda_low
);
   logic       nak;
   logic [7:0] pec;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      nak = 1'b0;
   end
   function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
      crc = c ^ d;
      for (int i = 0; i < 8; i++) crc = {crc[6:0], 1'b0} ^ (crc[7] ? 8'h07 : 8'h00);
   endfunction
   // clock stands high between frames; data moves mid-low only
   task automatic clk_bit(input logic bv, output logic r);
      #31.2 sda_low = ~bv;
      #31.3 scl = 1'b1;
      #31.2 r = sda_wire;
      #31.3 scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                       output logic k);
      for (int i = 7; i >= 0; i--) clk_bit(d[i], r[i]);
      clk_bit(a, k);
      pec = crc(pec, r);
   endtask
   task automatic start;
      #31.2 sda_low = 1'b0;
      #31.3 scl = 1'b1;
      #31.2 sda_low = 1'b1;
      #31.3 scl = 1'b0;
   endtask
   task automatic stop;
      #31.2 sda_low = 1'b1;
      #31.3 scl = 1'b1;
      #31.2 sda_low = 1'b0;
      #500;
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] v, input int n, input int bad);
      logic [7:0] r;
      logic       k;
      pec = 8'h00;
      start;
      xfer({dev_addr, 1'b0}, 1'b1, r, k);
      nak = k;
      xfer(cmd, 1'b1, r, k);
      xfer(v[7:0], 1'b1, r, k);
      if (n == 2) xfer(v[15:8], 1'b1, r, k);
      if (bad != 0) xfer(pec ^ 8'h01, 1'b1, r, k);
      stop;
   endtask
   task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] v);
      logic [7:0] r;
      logic       k;
      v = 16'h0000;
      pec = 8'h00;
      start;
      xfer({dev_addr, 1'b0}, 1'b1, r, k);
      nak = k;
      xfer(cmd, 1'b1, r, k);
      start;
      xfer({dev_addr, 1'b1}, 1'b1, r, k);
      xfer(8'hFF, n == 1, r, k);
      v[7:0] = r;
      if (n == 2) xfer(8'hFF, 1'b1, v[15:8], k);
      stop;
   endtask
   task automatic ara(output logic [7:0] v);
      logic k;
      start;
      xfer({7'h0C, 1'b1}, 1'b1, v, k);
      nak = k;
      xfer(8'hFF, 1'b1, v, k);
      stop;
   endtask
endmodule // smbus_host_model
`default_nettype wire

// [bench/pm_cmd_bank_test.sv]
// self-checking bench for the management command bank
`timescale 1ns/100ps
`default_nettype none
module pm_cmd_bank_test;
   localparam [5:0] NAME = 6'h25; // arbitrary designation, isolated kind
   localparam [7:0] FW   = 8'hC7;
   logic        clk_sys, rst, alert_line;
   logic [6:0]  addr_strap;
   logic [15:0] vin_meas, vout_meas, iout_meas, temp_meas, rv;
   logic [7:0]  b;
   wire         scl_pin, sda_low, sda_in, sda_out, sda_oe_n, write_protect_enable, ara_mode;
   wire         c1_secondary_onoff, c1_trim, c2_power_good, c2_secondary_onoff;
   wire [7:0]   comm_error_status;
   wire [15:0]  vo_read_gain_trim, vo_read_offset_trim, vi_read_gain_trim;
   wire [15:0]  vi_read_offset_trim, io_gain_trim, io_offset_trim;
   wire [10:0]  vi_offset_mantissa;
   wire [4:0]   pin_function_alert_cfg;
   int          mismatches, cmp_count;
   logic [7:0]  tcmd [4] = '{8'h88, 8'h8B, 8'h8C, 8'h8D};
   logic [15:0] tval [4] = '{16'h1234, 16'hA55A, 16'h0F0F, 16'h8001};
   logic [7:0]  gcmd [3] = '{8'hD1, 8'hD3, 8'hD6};
   logic [15:0] gv [4]   = '{16'h1999, 16'h2667, 16'h2666, 16'h1998};
   logic [15:0] ge [4]   = '{16'h1999, 16'h1999, 16'h2666, 16'h2666};
   logic [7:0]  ocmd [3] = '{8'hD2, 8'hD4, 8'hD7};
   logic [15:0] ov [3]   = '{16'hA123, 16'hED0F, 16'hE3AB};
   // open-drain wire with pull-up
   assign sda_in = sda_oe_n & ~sda_low;
   smbus_host_model host (.dev_addr(addr_strap), .sda_wire(sda_in), .scl(scl_pin),
                          .sda_low(sda_low));
   pm_cmd_bank #(.MODULE_NAME(NAME), .FW_REV(FW)) dut (.*);
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // whole sequence needs well under half a millisecond
   initial begin
      #600000;
      mismatches++;
      complete_run;
   end
   initial begin
      rst = 1'b1;
      alert_line = 1'b0;
      addr_strap = 7'h5A;
      {vin_meas, vout_meas, iout_meas, temp_meas} = {tval[0], tval[1], tval[2], tval[3]};
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      repeat (8) @(negedge clk_sys);
      host.rd(8'hD1, 2, rv);
      check(rv, 16'h2000);
      host.rd(8'hD3, 2, rv);
      check(rv, 16'h2000);
      host.rd(8'hD0, 2, rv);
      check(rv, {8'h00, NAME, 2'b00});
      host.rd(8'hDB, 1, rv);
      check(rv, {8'h00, FW});
      host.rd(8'hE0, 1, rv);
      check(rv, 16'h0000);
      host.rd(8'h7E, 1, rv);
      check(rv, 16'h0000);
      check({12'h000, c1_secondary_onoff, c2_power_good, c1_trim, c2_secondary_onoff}, 16'h000C);
      $display("reset values done");
      foreach (tcmd[i]) begin
         host.rd(tcmd[i], 2, rv);
         check(rv, tval[i]);
      end
      $display("telemetry done");
      foreach (gcmd[j]) begin
         for (int i = 0; i < 4; i++) begin
            host.wr(gcmd[j], gv[i], 2, 0);
            host.rd(gcmd[j], 2, rv);
            check(rv, ge[i]);
         end
      end
      host.rd(8'h7E, 1, rv);
      check(rv, 16'h0040);
      host.wr(8'h7E, 16'h0040, 1, 0);
      check({8'h00, comm_error_status}, 16'h0000);
      $display("gain limits done");
      foreach (ocmd[i]) begin
         host.wr(ocmd[i], ov[i], 2, 0);
         host.wr(ocmd[i], ov[(i + 1) % 3], 2, 0);
         host.rd(ocmd[i], 2, rv);
         check(rv, ov[i]);
      end
      check({5'h00, vi_offset_mantissa}, 16'h050F);
      $display("offset exponents done");
      host.rd(8'hA5, 1, rv);
      check(rv, 16'h00FF);
      host.wr(8'h88, 16'h0001, 2, 0);
      host.wr(8'hD1, 16'h2100, 2, 1);
      check(vo_read_gain_trim, 16'h2666);
      host.rd(8'h7E, 1, rv);
      check(rv, 16'h00E0);
      host.wr(8'h7E, 16'h00A0, 1, 0);
      host.rd(8'h7E, 1, rv);
      check(rv, 16'h0040);
      host.wr(8'h7E, 16'h00FF, 1, 0);
      $display("error flags done");
      host.wr(8'hD0, 16'h0002, 2, 0);
      check({15'h0000, write_protect_enable}, 16'h0001);
      host.wr(8'hD6, 16'h2100, 2, 0);
      check(io_gain_trim, 16'h2666);
      check({8'h00, comm_error_status}, 16'h0040);
      host.wr(8'hD0, 16'h0000, 2, 0);
      host.wr(8'hD6, 16'h2100, 2, 0);
      check(io_gain_trim, 16'h2100);
      $display("write protect done");
      host.wr(8'hE0, 16'h00F2, 1, 0);
      host.rd(8'hE0, 1, rv);
      check(rv, 16'h0012);
      check({12'h000, c1_secondary_onoff, c2_power_good, c1_trim, c2_secondary_onoff}, 16'h0003);
      @(negedge clk_sys) alert_line = 1'b1;
      host.ara(b);
      check({8'h00, b}, {8'h00, addr_strap, 1'b0});
      host.rd(8'hE0, 1, rv);
      check({15'h0000, host.nak}, 16'h0001);
      @(negedge clk_sys) alert_line = 1'b0;
      host.wr(8'hE0, 16'h0005, 1, 0);
      check({11'h000, pin_function_alert_cfg}, 16'h0012);
      host.wr(8'hE0, 16'h0000, 1, 0);
      @(negedge clk_sys) alert_line = 1'b1;
      host.rd(8'hE0, 1, rv);
      check({15'h0000, host.nak}, 16'h0000);
      check(rv, 16'h0000);
      $display("pin config done");
      complete_run;
   end
endmodule // pm_cmd_bank_test
bind pm_cmd_bank pm_cmd_bank_properties chk (.*);
`default_nettype wire
